//--- core/msk_cfg.svh
// Constants for the modem frame detector: offsets, fields, reset values and timing.
// Function
// - Bit one gives 1200 Hz, zero 1800 Hz.
// - Transmit clock driven out; bit sampled on rise.
// - Receive bit updates on receive clock rise.
// - Digital loop recovers receive clock from transitions.
// - Match flag rises on pattern match, stays.
// - Check select high: shift clock shifts out.
// - Serial port sets modes and loads pattern.
// - Clocks divided from 3.6864 or 3.456 MHz crystal.
// - Tone present while smoothed level exceeds reference.
// - Bit rate 1200, one clock per bit.
// - Check select high: serial input shifts in.
// - Shifted word takes effect on strobe rise.
// - Select low loads mode, high loads pattern.
// - Clear input low forces match flag low.
`ifndef MSK_CFG_SVH
`define MSK_CFG_SVH
`define MSK_XTAL_HZ 3686400
`define MSK_XTAL_ALT_HZ 3456000
`define MSK_BIT_HZ 1200
`define MSK_TONE_ONE_HZ 1200
`define MSK_TONE_ZERO_HZ 1800
`define MSK_WORD_W 16
`define MSK_MODE_RST 16'h0004
`define MSK_STBY_LSB 0
`define MSK_TX_MUTE_BIT 3
`define MSK_RX_MUTE_BIT 4
`define MSK_REG_CTRL 8'h00
`define MSK_REG_STATUS 8'h04
`define MSK_REG_IRQ_STAT 8'h08
`define MSK_REG_IRQ_CLR 8'h0C
`define MSK_REG_IRQ_EN 8'h10
`define MSK_REG_PATTERN 8'h14
`define MSK_EV_MATCH 0
`define MSK_EV_TONE 1
`define MSK_EV_LOAD 2
`define MSK_EV_W 3
`define MSK_RESP_OKAY 2'h0
`define MSK_RESP_SLVERR 2'h2
`endif

//--- core/msk_pkg.sv
// Types shared by the modem frame detector files.
`include "msk_cfg.svh"
package msk_pkg;
    typedef struct packed {
        logic xtal_prev;
        logic xtal_out;
        logic [11:0] tx_cnt;
        logic tx_bit;
        logic [31:0] tx_phase;
        logic [7:0] tone;
        logic [11:0] rx_cnt;
        logic demod_prev;
        logic rx_bit;
        logic [`MSK_WORD_W-1:0] rx_win;
        logic match;
        logic sck_prev;
        logic stb_prev;
        logic [`MSK_WORD_W-1:0] cfg_sr;
        logic chk_out;
        logic [`MSK_WORD_W-1:0] mode;
        logic [`MSK_WORD_W-1:0] pattern;
        logic [11:0] tone_acc;
        logic tone_det;
        logic ctrl_alt;
        logic [`MSK_EV_W-1:0] irq_stat;
        logic [`MSK_EV_W-1:0] irq_en;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } msk_state_type;
endpackage

//--- core/msk_sine_rom.sv
// Sine lookup with registered read data.
`timescale 1ns/1ps
module msk_sine_rom
(
    input wire logic aclk,
    input wire logic [3:0] addr,
    output logic [7:0] data
);
    always_ff @(posedge aclk)
    begin
        unique case (addr)
            4'h0: data <= 8'h00;
            4'h1: data <= 8'h31;
            4'h2: data <= 8'h5A;
            4'h3: data <= 8'h75;
            4'h4: data <= 8'h7F;
            4'h5: data <= 8'h75;
            4'h6: data <= 8'h5A;
            4'h7: data <= 8'h31;
            4'h8: data <= 8'h00;
            4'h9: data <= 8'hCF;
            4'hA: data <= 8'hA6;
            4'hB: data <= 8'h8B;
            4'hC: data <= 8'h81;
            4'hD: data <= 8'h8B;
            4'hE: data <= 8'hA6;
            4'hF: data <= 8'hCF;
        endcase
    end
endmodule

//--- core/msk_top.sv
// Digital core of the voice-band modem: tones, bit clock recovery, frame match, serial setup.
`timescale 1ns/1ps
`include "msk_cfg.svh"
module msk_top
#(
    parameter logic [11:0] DIV_MAIN = 12'(`MSK_XTAL_HZ / `MSK_BIT_HZ),
    parameter logic [11:0] DIV_ALT = 12'(`MSK_XTAL_ALT_HZ / `MSK_BIT_HZ)
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    input wire logic xtal_in,
    output logic xtal_out,
    input wire logic tx_bit_in,
    output logic tx_bit_clock,
    output logic [7:0] tone_out,
    input wire logic rx_demod_bit,
    output logic rx_bit_out,
    output logic rx_bit_clock,
    output logic frame_match_flag,
    input wire logic match_flag_clear,
    input wire logic serial_in,
    input wire logic serial_shift_clock,
    input wire logic serial_load_strobe,
    input wire logic pattern_select,
    input wire logic pattern_check_select,
    output logic pattern_check_out,
    input wire logic [7:0] tone_sample,
    input wire logic [7:0] tone_ref
);
    import msk_pkg::*;

    localparam logic [31:0] INC_ONE_MAIN = 32'((64'(`MSK_TONE_ONE_HZ) << 32) / 64'(`MSK_XTAL_HZ));
    localparam logic [31:0] INC_ZERO_MAIN = 32'((64'(`MSK_TONE_ZERO_HZ) << 32) / 64'(`MSK_XTAL_HZ));
    localparam logic [31:0] INC_ONE_ALT = 32'((64'(`MSK_TONE_ONE_HZ) << 32) / 64'(`MSK_XTAL_ALT_HZ));
    localparam logic [31:0] INC_ZERO_ALT = 32'((64'(`MSK_TONE_ZERO_HZ) << 32) / 64'(`MSK_XTAL_ALT_HZ));

    msk_state_type s_q;
    msk_state_type s_d;
    logic tick;
    logic [11:0] div;
    logic [11:0] half;
    logic [31:0] inc;
    logic [2:0] stby;
    logic tx_on;
    logic rx_on;
    logic det_on;
    logic [7:0] rom_data;
    logic [`MSK_WORD_W-1:0] win_n;
    logic [7:0] mag;
    logic sck_rise;
    logic stb_rise;
    logic [`MSK_EV_W-1:0] ev;
    logic [`MSK_EV_W-1:0] clr;
    logic rd_go;

    // ----------------------------------------------------------------
    // Timing base and mode decode
    // ----------------------------------------------------------------
    assign tick = xtal_in && !s_q.xtal_prev;
    assign div = s_q.ctrl_alt ? DIV_ALT : DIV_MAIN;
    assign half = {1'b0, div[11:1]};
    assign stby = s_q.mode[`MSK_STBY_LSB+2:`MSK_STBY_LSB];
    assign tx_on = (stby == 3'h0);
    assign rx_on = (stby == 3'h0) || (stby == 3'h2) || (stby == 3'h3);
    assign det_on = (stby < 3'h4);
    assign inc = s_q.tx_bit ? (s_q.ctrl_alt ? INC_ONE_ALT : INC_ONE_MAIN) :
                 (s_q.ctrl_alt ? INC_ZERO_ALT : INC_ZERO_MAIN);
    assign win_n = {s_q.rx_win[`MSK_WORD_W-2:0], rx_demod_bit};
    assign mag = tone_sample[7] ? 8'(-tone_sample) : tone_sample;
    assign sck_rise = serial_shift_clock && !s_q.sck_prev;
    assign stb_rise = serial_load_strobe && !s_q.stb_prev;
    assign rd_go = s_axi_arvalid && !s_q.rvalid;

    msk_sine_rom u_rom
    (
        .aclk(aclk),
        .addr(s_q.tx_phase[31:28]),
        .data(rom_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        s_d.xtal_prev = xtal_in;
        s_d.xtal_out = !xtal_in;
        s_d.sck_prev = serial_shift_clock;
        s_d.stb_prev = serial_load_strobe;
        s_d.tone = (tx_on && !s_q.mode[`MSK_TX_MUTE_BIT]) ? rom_data : 8'h00;
        if (tick)
        begin
            if (s_q.tx_cnt >= div - 12'h001)
            begin
                s_d.tx_cnt = 12'h000;
                s_d.tx_bit = tx_bit_in;
            end
            else
            begin
                s_d.tx_cnt = s_q.tx_cnt + 12'h001;
            end
            s_d.tx_phase = tx_on ? s_q.tx_phase + inc : 32'h00000000;
            if (det_on)
            begin
                s_d.tone_acc = s_q.tone_acc + {4'h0, mag} - {4'h0, s_q.tone_acc[11:4]};
            end
            s_d.demod_prev = rx_demod_bit;
            if (rx_on)
            begin
                if (rx_demod_bit != s_q.demod_prev)
                begin
                    s_d.rx_cnt = half;
                end
                else if (s_q.rx_cnt >= div - 12'h001)
                begin
                    s_d.rx_cnt = 12'h000;
                    s_d.rx_bit = rx_demod_bit;
                    s_d.rx_win = win_n;
                    if (win_n == s_q.pattern)
                    begin
                        s_d.match = 1'b1;
                    end
                end
                else
                begin
                    s_d.rx_cnt = s_q.rx_cnt + 12'h001;
                end
            end
        end
        s_d.tone_det = det_on && (s_q.tone_acc[11:4] > tone_ref);
        if (!match_flag_clear)
        begin
            s_d.match = 1'b0;
        end
        if (sck_rise)
        begin
            if (pattern_check_select)
            begin
                s_d.cfg_sr = {s_q.cfg_sr[`MSK_WORD_W-2:0], serial_in};
                s_d.chk_out = s_q.cfg_sr[`MSK_WORD_W-1];
            end
            else
            begin
                s_d.cfg_sr = pattern_select ? s_q.pattern : s_q.mode;
            end
        end
        if (stb_rise)
        begin
            ev[`MSK_EV_LOAD] = 1'b1;
            if (pattern_select)
            begin
                s_d.pattern = s_q.cfg_sr;
            end
            else
            begin
                s_d.mode = s_q.cfg_sr;
            end
        end
        ev[`MSK_EV_MATCH] = s_d.match && !s_q.match;
        ev[`MSK_EV_TONE] = s_d.tone_det && !s_q.tone_det;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `MSK_RESP_OKAY;
            unique case (s_q.awaddr)
                `MSK_REG_CTRL:
                begin
                    if (s_q.wstrb[0])
                    begin
                        s_d.ctrl_alt = s_q.wdata[0];
                    end
                end
                `MSK_REG_IRQ_CLR:
                begin
                    if (s_q.wstrb[0])
                    begin
                        clr = s_q.wdata[`MSK_EV_W-1:0];
                    end
                end
                `MSK_REG_IRQ_EN:
                begin
                    if (s_q.wstrb[0])
                    begin
                        s_d.irq_en = s_q.wdata[`MSK_EV_W-1:0];
                    end
                end
                `MSK_REG_STATUS, `MSK_REG_IRQ_STAT, `MSK_REG_PATTERN:
                begin
                    s_d.bresp = `MSK_RESP_OKAY;
                end
                default:
                begin
                    s_d.bresp = `MSK_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (rd_go)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `MSK_RESP_OKAY;
            s_d.rdata = 32'h00000000;
            unique case (s_axi_araddr)
                `MSK_REG_CTRL: s_d.rdata = {31'h0, s_q.ctrl_alt};
                `MSK_REG_STATUS: s_d.rdata = {s_q.mode, 13'h0, s_q.rx_bit, s_q.tone_det, s_q.match};
                `MSK_REG_IRQ_STAT: s_d.rdata = {29'h0, s_q.irq_stat};
                `MSK_REG_IRQ_CLR: s_d.rdata = 32'h00000000;
                `MSK_REG_IRQ_EN: s_d.rdata = {29'h0, s_q.irq_en};
                `MSK_REG_PATTERN: s_d.rdata = {16'h0, s_q.pattern};
                default: s_d.rresp = `MSK_RESP_SLVERR;
            endcase
        end
        if (!aresetn)
        begin
            s_d = '0;
            s_d.mode = `MSK_MODE_RST;
        end
    end

    always_ff @(posedge aclk)
    begin
        s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign irq = |(s_q.irq_stat & s_q.irq_en);
    assign xtal_out = s_q.xtal_out;
    assign tx_bit_clock = (s_q.tx_cnt < half);
    assign tone_out = s_q.tone;
    assign rx_bit_out = s_q.rx_bit;
    assign rx_bit_clock = (s_q.rx_cnt < half);
    assign frame_match_flag = s_q.match;
    assign pattern_check_out = s_q.chk_out;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_match_clear: assert property (!match_flag_clear |=> !frame_match_flag)
        else $error("Match flag not cleared.");
    a_match_sticky: assert property (frame_match_flag && match_flag_clear |=> frame_match_flag)
        else $error("Match flag dropped.");
    a_match_cause: assert property ($rose(frame_match_flag) |-> s_q.rx_win == s_q.pattern)
        else $error("Match flag without match.");
    a_rx_on_clock: assert property ($changed(rx_bit_out) |-> $rose(rx_bit_clock))
        else $error("Receive bit moved off clock edge.");
    a_tx_sample: assert property ($rose(tx_bit_clock) |-> s_q.tx_bit == $past(tx_bit_in))
        else $error("Transmit bit not sampled.");
    a_cfg_shift_in: assert property (sck_rise && pattern_check_select
        |=> s_q.cfg_sr[0] == $past(serial_in))
        else $error("Serial bit not shifted in.");
    a_check_out: assert property (sck_rise && pattern_check_select
        |=> pattern_check_out == $past(s_q.cfg_sr[`MSK_WORD_W-1]))
        else $error("Check output wrong.");
    a_mode_load: assert property (stb_rise && !pattern_select |=> s_q.mode == $past(s_q.cfg_sr))
        else $error("Mode word not loaded.");
    a_tone_mute: assert property (s_q.mode[`MSK_TX_MUTE_BIT] ##1 s_q.mode[`MSK_TX_MUTE_BIT]
        |-> tone_out == 8'h00)
        else $error("Muted tone not silent.");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped.");

    c_match: cover property ($rose(frame_match_flag));
    c_tone: cover property ($rose(s_q.tone_det));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_pattern: cover property (stb_rise && pattern_select);
endmodule

//--- tb/msk_proc_model.sv
// Processor-side model: serial setup port, frame latch clear and transmit bit source.
`timescale 1ns/1ps
module msk_proc_model
(
    input wire logic aclk,
    input wire logic tx_bit_clock,
    input wire logic pattern_check_out,
    output logic tx_bit_in,
    output logic serial_in,
    output logic serial_shift_clock,
    output logic serial_load_strobe,
    output logic pattern_select,
    output logic pattern_check_select,
    output logic match_flag_clear,
    output logic [15:0] chk_seen
);
    logic [15:0] tx_word;
    logic tck_q;

    initial
    begin
        tx_word = 16'hC35A;
        tck_q = 1'b1;
        tx_bit_in = 1'b0;
        serial_in = 1'b0;
        serial_shift_clock = 1'b0;
        serial_load_strobe = 1'b0;
        pattern_select = 1'b0;
        pattern_check_select = 1'b0;
        match_flag_clear = 1'b1;
        chk_seen = 16'h0000;
    end

    // A new transmit bit appears on the falling bit clock, so it is stable around the rise.
    always @(posedge aclk)
    begin
        tck_q <= tx_bit_clock;
        if (tck_q && !tx_bit_clock)
        begin
            tx_word <= {tx_word[14:0], tx_word[15]};
            tx_bit_in <= tx_word[15];
        end
    end

    // Shifts a word in MSB first, records the bits shifted out, then strobes it in.
    task automatic send_word(input logic [15:0] w, input logic sel);
        begin
            pattern_check_select <= 1'b1;
            pattern_select <= sel;
            for (int i = 15; i >= 0; i--)
            begin
                serial_in <= w[i];
                repeat (2) @(posedge aclk);
                serial_shift_clock <= 1'b1;
                repeat (2) @(posedge aclk);
                serial_shift_clock <= 1'b0;
                chk_seen <= {chk_seen[14:0], pattern_check_out};
            end
            repeat (2) @(posedge aclk);
            serial_load_strobe <= 1'b1;
            repeat (2) @(posedge aclk);
            serial_load_strobe <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask

    // Holds the latch clear low for three cycles.
    task automatic clr_pulse;
        begin
            match_flag_clear <= 1'b0;
            repeat (3) @(posedge aclk);
            match_flag_clear <= 1'b1;
        end
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the modem core.
`timescale 1ns/1ps
`include "msk_cfg.svh"
module tb_top;
    localparam logic [15:0] PAT = 16'hA5C3;
    localparam int BIT_CYC = 64;
    logic aclk, aresetn, xtal_in, rx_demod_bit, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, tx_bit_clock, tx_bit_in, rx_bit_out, rx_bit_clock;
    logic flag, pco, serial_in, sck, stb, psel, pcs, mfc;
    logic [1:0] xd, bresp, rresp;
    logic [7:0] awaddr, araddr, tone_sample, tone_ref, tone_out, acc;
    logic [31:0] wdata, rdata, rd;
    logic [15:0] chk_seen;
    logic xo, xi_q;
    int n_fail, checked, n;

    msk_top #(.DIV_MAIN(12'h010), .DIV_ALT(12'h00F)) uut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .xtal_in(xtal_in), .xtal_out(xo),
        .tx_bit_in(tx_bit_in), .tx_bit_clock(tx_bit_clock), .tone_out(tone_out), .rx_demod_bit(rx_demod_bit),
        .rx_bit_out(rx_bit_out), .rx_bit_clock(rx_bit_clock), .frame_match_flag(flag), .match_flag_clear(mfc),
        .serial_in(serial_in), .serial_shift_clock(sck), .serial_load_strobe(stb), .pattern_select(psel),
        .pattern_check_select(pcs), .pattern_check_out(pco), .tone_sample(tone_sample), .tone_ref(tone_ref)
    );

    msk_proc_model proc
    (
        .aclk(aclk), .tx_bit_clock(tx_bit_clock), .pattern_check_out(pco), .tx_bit_in(tx_bit_in),
        .serial_in(serial_in), .serial_shift_clock(sck), .serial_load_strobe(stb), .pattern_select(psel),
        .pattern_check_select(pcs), .match_flag_clear(mfc), .chk_seen(chk_seen)
    );

    assign xtal_in = xd[1];

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) xd <= xd + 2'h1;
    always @(posedge aclk) xi_q <= xtal_in;

    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        begin
            checked++;
            if (got !== exp)
            begin
                n_fail++;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (1)
            begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) break;
            end
            bready <= 1'b0;
            chk("bresp", 32'(bresp), 32'(er));
        end
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            while (1)
            begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) break;
            end
            rready <= 1'b0;
            rd = rdata;
            chk("rresp", 32'(rresp), 32'(er));
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        begin
            axr(a, `MSK_RESP_OKAY);
            chk(nm, rd & m, e);
        end
    endtask

    // Cycles between two rises of the transmit (sel low) or receive (sel high) bit clock.
    task automatic per(input logic sel, output int c);
        logic p;
        logic k;
        begin
            p = sel ? rx_bit_clock : tx_bit_clock;
            c = -1;
            while (1)
            begin
                @(posedge aclk);
                k = sel ? rx_bit_clock : tx_bit_clock;
                if (c >= 0) c++;
                if (k && !p)
                begin
                    if (c > 0) break;
                    c = 0;
                end
                p = k;
            end
        end
    endtask

    // ORs the tone output over 200 cycles.
    task automatic tone_any;
        begin
            acc = 8'h00;
            repeat (200)
            begin
                @(posedge aclk);
                acc = acc | tone_out;
            end
        end
    endtask

    task automatic results;
        begin
            $display("checks %0d failures %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // ------------------------------
    // Tests
    // ------------------------------
    initial
    begin
        {aresetn, xd, rx_demod_bit, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, tone_sample} = '0;
        tone_ref = 8'h32;
        n_fail = 0;
        checked = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`MSK_REG_STATUS, 32'hFFFF0007, 32'h00040000, "status_reset");
        chk("xtal_out", 32'(xo), 32'(!xi_q));
        rdc(`MSK_REG_PATTERN, 32'h0000FFFF, 32'h0, "pattern_reset");
        axr(8'h40, `MSK_RESP_SLVERR);
        chk("unmapped_rdata", rd, 32'h0);
        axw(8'h44, 32'h1, `MSK_RESP_SLVERR);
        axw(`MSK_REG_IRQ_EN, 32'h7, `MSK_RESP_OKAY);
        proc.send_word(PAT, 1'b1);
        chk("shift_out_first", 32'(chk_seen), 32'h0);
        rdc(`MSK_REG_PATTERN, 32'h0000FFFF, 32'(PAT), "pattern");
        chk("irq_load", 32'(irq), 32'h1);
        axw(`MSK_REG_IRQ_CLR, 32'h4, `MSK_RESP_OKAY);
        chk("irq_cleared", 32'(irq), 32'h0);
        axw(`MSK_REG_IRQ_EN, 32'h3, `MSK_RESP_OKAY);
        proc.send_word(16'h0000, 1'b0);
        chk("shift_out_pat", 32'(chk_seen), 32'(PAT));
        rdc(`MSK_REG_STATUS, 32'hFFFF0000, 32'h0, "mode_word");
        rdc(`MSK_REG_IRQ_STAT, 32'h4, 32'h4, "stat_masked");
        chk("irq_masked", 32'(irq), 32'h0);
        axw(`MSK_REG_IRQ_CLR, 32'h7, `MSK_RESP_OKAY);
        tone_sample <= 8'h64;
        repeat (1000) @(posedge aclk);
        rdc(`MSK_REG_STATUS, 32'h2, 32'h2, "tone_on");
        chk("irq_tone", 32'(irq), 32'h1);
        tone_sample <= 8'h00;
        repeat (1500) @(posedge aclk);
        rdc(`MSK_REG_STATUS, 32'h2, 32'h0, "tone_off");
        axw(`MSK_REG_IRQ_CLR, 32'h2, `MSK_RESP_OKAY);
        per(1'b0, n);
        chk("tx_period", 32'(n), 32'(BIT_CYC));
        tone_any();
        chk("tone_live", 32'(acc != 8'h00), 32'h1);
        axw(`MSK_REG_CTRL, 32'h1, `MSK_RESP_OKAY);
        rdc(`MSK_REG_CTRL, 32'h1, 32'h1, "ctrl");
        per(1'b0, n);
        per(1'b0, n);
        chk("tx_period_alt", 32'(n), 32'h3C);
        axw(`MSK_REG_CTRL, 32'h0, `MSK_RESP_OKAY);
        proc.send_word(16'h0008, 1'b0);
        repeat (10) @(posedge aclk);
        tone_any();
        chk("tone_muted", 32'(acc), 32'h0);
        proc.send_word(16'h0002, 1'b0);
        tone_any();
        chk("tone_standby", 32'(acc), 32'h0);
        proc.clr_pulse();
        chk("flag_clear", 32'(flag), 32'h0);
        for (int i = 15; i >= 0; i--)
        begin
            if (i == 0) chk("flag_early", 32'(flag), 32'h0);
            rx_demod_bit <= PAT[i];
            repeat (BIT_CYC) @(posedge aclk);
        end
        chk("flag_match", 32'(flag), 32'h1);
        chk("rx_bit", 32'(rx_bit_out), 32'(PAT[0]));
        rx_demod_bit <= ~PAT[0];
        repeat (2 * BIT_CYC) @(posedge aclk);
        chk("flag_sticky", 32'(flag), 32'h1);
        per(1'b1, n);
        chk("rx_period", 32'(n), 32'(BIT_CYC));
        chk("irq_match", 32'(irq), 32'h1);
        rdc(`MSK_REG_IRQ_STAT, 32'h1, 32'h1, "stat_match");
        proc.clr_pulse();
        chk("flag_cleared", 32'(flag), 32'h0);
        results();
    end

    initial
    begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        results();
    end
endmodule
